// ==== rtl/pfmpc_pkg.sv ====
`default_nettype none
package pfmpc_pkg;
  localparam int unsigned PFMPC_PORTS = 4;
  // Management register numbers and bit positions.
  localparam logic [4:0] PFMPC_REG_CTRL = 5'h00;
  localparam logic [4:0] PFMPC_REG_VEND = 5'h1D;
  localparam int unsigned PFMPC_BIT_DUPLEX = 8;
  localparam int unsigned PFMPC_BIT_FIBER = 0;
  // Reset value of the management registers before any strap is caught.
  localparam logic [15:0] PFMPC_REG_RESET = 16'h0000;
  // Register address layout on the plain port: port index above register number.
  localparam int unsigned PFMPC_ADDR_W = 7;
  localparam int unsigned PFMPC_PORT_LSB = 5;
  // Status register of the block's own state, and the unmapped read answer.
  localparam logic [4:0] PFMPC_REG_STAT = 5'h1E;
  localparam logic [15:0] PFMPC_UNMAPPED = 16'h0000;
  // Copper-side options when not forced: autonegotiation in the control register, the rest in the vendor register.
  localparam int unsigned PFMPC_BIT_ANEG = 12;
  localparam int unsigned PFMPC_BIT_SCR_BYP = 1;
  localparam int unsigned PFMPC_BIT_ENC_BYP = 2;
  localparam int unsigned PFMPC_BIT_FEF = 3;
  localparam int unsigned PFMPC_BIT_TEN_OFF = 4;
  typedef enum logic [1:0] {PFMPC_NORMAL, PFMPC_SEPARATE, PFMPC_SMART} pfmpc_bus_mode_t;
endpackage
`default_nettype wire

// ==== rtl/pfmpc_bus_route.sv ====
`timescale 1ns/10ps
`default_nettype none
// Repeater control pin mapping for the bused modes.
module pfmpc_bus_route
  import pfmpc_pkg::*;
#(
  parameter int unsigned PORTS = PFMPC_PORTS
) (
  input wire pfmpc_bus_mode_t mode,
  input wire logic [PORTS-1:0] port_fast,
  input wire logic [PORTS-1:0] carrier_sense_slow,
  input wire logic [PORTS-1:0] carrier_sense_fast,
  input wire logic [PORTS-1:0] receive_enable_slow,
  input wire logic [PORTS-1:0] receive_enable_fast,
  input wire logic [PORTS-1:0] transmit_enable_slow,
  input wire logic [PORTS-1:0] transmit_enable_fast,
  output logic [PORTS-1:0] carrier_sense_out,
  output logic [PORTS-1:0] rx_select,
  output logic [PORTS-1:0] tx_select,
  output logic [PORTS-1:0] to_bus_a,
  output logic [PORTS-1:0] to_bus_b,
  output logic [PORTS-1:0] security
);
  always_comb begin
    carrier_sense_out = '0;
    rx_select = '0;
    tx_select = '0;
    to_bus_a = '0;
    to_bus_b = '0;
    security = '0;
    unique case (mode)
      PFMPC_NORMAL: begin
        carrier_sense_out = carrier_sense_fast;
      end
      PFMPC_SEPARATE: begin
        to_bus_a = port_fast;
        to_bus_b = ~port_fast;
        carrier_sense_out = (carrier_sense_fast & port_fast) | (carrier_sense_slow & ~port_fast);
        rx_select = (receive_enable_fast & port_fast) | (receive_enable_slow & ~port_fast);
        tx_select = (transmit_enable_fast & port_fast) | (transmit_enable_slow & ~port_fast);
      end
      PFMPC_SMART: begin
        to_bus_a = port_fast;
        to_bus_b = ~port_fast;
        carrier_sense_out = carrier_sense_fast;
        rx_select = receive_enable_fast;
        tx_select = transmit_enable_fast;
        security = transmit_enable_slow;
      end
      // The mode pins are undecoded code 3 here; every route stays off.
      default: begin
        carrier_sense_out = '0;
      end
    endcase
  end
endmodule
`default_nettype wire

// ==== rtl/pfmpc_top.sv ====
// Our own choices: the placing of the registers and the strobed register port.
`timescale 1ns/10ps
`default_nettype none
// Function
// - Each port enters fiber mode independently by its strap or by a register 29 bit 0.
// - Fiber mode runs full or half duplex, set per port by register 0 bit 8.
// - One strap, caught at power-up and reset, sets the duplex of all ports together.
// - In fiber mode the copper pins carry fiber data and signal detect is enabled.
// - Fiber mode forces its options and register control of them is ignored.
// - Fiber mode enables far-end fault signalling.
// - Fiber mode bypasses the three-level line coder.
// - Fiber mode bypasses scrambler and descrambler.
// - Fiber mode holds autonegotiation off and sends no link pulses.
// - Fiber mode disables 10 Mbit/s twisted-pair operation.
// - Smart bused mode merges control pins and turns slow transmit enables into security.
// - Bused mode sends fast ports to interface A and slow ports to interface B.
module pfmpc_top
  import pfmpc_pkg::*;
#(
  parameter int unsigned PORTS = PFMPC_PORTS
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [PFMPC_ADDR_W-1:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic [PORTS-1:0] fiber_select_strap,
  input wire logic global_duplex_strap,
  input wire logic [PORTS-1:0] optic_signal_detect,
  input wire logic [PORTS-1:0] link_fast,
  input wire pfmpc_bus_mode_t bus_mode,
  input wire logic [PORTS-1:0] carrier_sense_slow,
  input wire logic [PORTS-1:0] carrier_sense_fast,
  input wire logic [PORTS-1:0] receive_enable_slow,
  input wire logic [PORTS-1:0] receive_enable_fast,
  input wire logic [PORTS-1:0] transmit_enable_slow,
  input wire logic [PORTS-1:0] transmit_enable_fast,
  output logic [PORTS-1:0] fiber_active,
  output logic [PORTS-1:0] full_duplex,
  output logic [PORTS-1:0] pins_to_fiber,
  output logic [PORTS-1:0] signal_detect_on,
  output logic [PORTS-1:0] signal_present,
  output logic [PORTS-1:0] far_fault_en,
  output logic [PORTS-1:0] line_code_bypass,
  output logic [PORTS-1:0] scramble_bypass,
  output logic [PORTS-1:0] autoneg_en,
  output logic [PORTS-1:0] link_pulse_en,
  output logic [PORTS-1:0] slow_enable,
  output logic [PORTS-1:0] port_fast,
  output logic [PORTS-1:0] carrier_sense_out,
  output logic [PORTS-1:0] rx_select,
  output logic [PORTS-1:0] tx_select,
  output logic [PORTS-1:0] to_bus_a,
  output logic [PORTS-1:0] to_bus_b,
  output logic [PORTS-1:0] security
);

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  // The port field of the address limits how many ports software can reach.
  if (PORTS < 1 || PORTS > (1 << (PFMPC_ADDR_W - PFMPC_PORT_LSB))) begin : g_ports_bad
    $error("pfmpc_top: PORTS out of range");
  end

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [15:0] ctrl_r [PORTS];
  logic [15:0] vend_r [PORTS];
  logic strap_pending_r;
  logic [PORTS-1:0] fiber_mode;
  logic [PORTS-1:0] fast_sel;
  logic [PORTS-1:0] cso_w, rxs_w, txs_w, bua_w, bub_w, sec_w;
  logic [4:0] addr_reg;
  logic [PFMPC_ADDR_W-PFMPC_PORT_LSB-1:0] addr_port;

  assign addr_reg = reg_addr[PFMPC_PORT_LSB-1:0];
  assign addr_port = reg_addr[PFMPC_ADDR_W-1:PFMPC_PORT_LSB];

  function automatic logic port_hit(input int unsigned p);
    return (int'(addr_port) == p);
  endfunction

  function automatic logic reg_sel(input int unsigned p, input logic [4:0] r);
    return port_hit(p) && (addr_reg == r);
  endfunction

  // An option that fiber mode forces on, else the register bit decides.
  function automatic logic forced_on(input logic fiber, input logic bit_val);
    return fiber | bit_val;
  endfunction

  // An option that fiber mode forces off, else the register bit decides.
  function automatic logic copper_only(input logic fiber, input logic bit_val);
    return ~fiber & bit_val;
  endfunction

  // Straps are caught on the first clock after reset release; a reset flop
  // may not load a pin, so a pending flag marks the sampling edge.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      strap_pending_r <= 1'b1;
    end else begin
      strap_pending_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  // The strap load wins over a write in the same cycle; requests are not
  // allowed before the second edge after reset, so nothing real is lost.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      for (int p = 0; p < PORTS; p++) begin
        ctrl_r[p] <= PFMPC_REG_RESET;
      end
    end else if (strap_pending_r) begin
      for (int p = 0; p < PORTS; p++) begin
        ctrl_r[p][PFMPC_BIT_DUPLEX] <= global_duplex_strap;
      end
    end else if (reg_wr) begin
      for (int p = 0; p < PORTS; p++) begin
        if (reg_sel(p, PFMPC_REG_CTRL)) begin
          ctrl_r[p] <= reg_wdata;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Vendor register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      for (int p = 0; p < PORTS; p++) begin
        vend_r[p] <= PFMPC_REG_RESET;
      end
    end else if (strap_pending_r) begin
      for (int p = 0; p < PORTS; p++) begin
        vend_r[p][PFMPC_BIT_FIBER] <= fiber_select_strap[p];
      end
    end else if (reg_wr) begin
      for (int p = 0; p < PORTS; p++) begin
        if (reg_sel(p, PFMPC_REG_VEND)) begin
          vend_r[p] <= reg_wdata;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Register read
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      reg_rdata <= PFMPC_UNMAPPED;
    end else if (reg_rd) begin
      reg_rdata <= PFMPC_UNMAPPED;
      for (int p = 0; p < PORTS; p++) begin
        if (port_hit(p)) begin
          unique case (addr_reg)
            PFMPC_REG_CTRL: reg_rdata <= ctrl_r[p];
            PFMPC_REG_VEND: reg_rdata <= vend_r[p];
            PFMPC_REG_STAT: reg_rdata <= {13'h0000, optic_signal_detect[p],
                                          fast_sel[p], fiber_mode[p]};
            default: reg_rdata <= PFMPC_UNMAPPED;
          endcase
        end
      end
    end else begin
      reg_rdata <= PFMPC_UNMAPPED;
    end
  end

  // ----------------------------------------------------------------
  // Per-port option forcing
  // ----------------------------------------------------------------
  always_comb begin
    for (int p = 0; p < PORTS; p++) begin
      fiber_mode[p] = vend_r[p][PFMPC_BIT_FIBER];
      fast_sel[p] = fiber_mode[p] | link_fast[p];
    end
  end

  // ----------------------------------------------------------------
  // Fiber path and signal detect
  // ----------------------------------------------------------------
  // The signal detect pins are masked at signal_present on copper ports, where the same pins
  // carry twisted-pair data and would show noise as a false detect.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      fiber_active <= '0;
      pins_to_fiber <= '0;
      signal_detect_on <= '0;
      signal_present <= '0;
    end else begin
      for (int p = 0; p < PORTS; p++) begin
        fiber_active[p] <= fiber_mode[p];
        pins_to_fiber[p] <= fiber_mode[p];
        signal_detect_on[p] <= fiber_mode[p];
        signal_present[p] <= fiber_mode[p] & optic_signal_detect[p];
      end
    end
  end

  // ----------------------------------------------------------------
  // Duplex
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      full_duplex <= '0;
    end else begin
      for (int p = 0; p < PORTS; p++) begin
        full_duplex[p] <= ctrl_r[p][PFMPC_BIT_DUPLEX];
      end
    end
  end

  // ----------------------------------------------------------------
  // Forced coding options
  // ----------------------------------------------------------------
  // Forcing wins over the register bits, so software cannot turn a fiber
  // port back into a copper configuration without clearing the fiber bit.
  // forced options ignore bits
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      far_fault_en <= '0;
    end else begin
      for (int p = 0; p < PORTS; p++) begin
        far_fault_en[p] <= forced_on(fiber_mode[p], vend_r[p][PFMPC_BIT_FEF]);
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      line_code_bypass <= '0;
    end else begin
      for (int p = 0; p < PORTS; p++) begin
        line_code_bypass[p] <= forced_on(fiber_mode[p], vend_r[p][PFMPC_BIT_ENC_BYP]);
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      scramble_bypass <= '0;
    end else begin
      for (int p = 0; p < PORTS; p++) begin
        scramble_bypass[p] <= forced_on(fiber_mode[p], vend_r[p][PFMPC_BIT_SCR_BYP]);
      end
    end
  end

  // ----------------------------------------------------------------
  // Autonegotiation
  // ----------------------------------------------------------------
  // Link pulses follow autonegotiation; a fiber port must stay silent on
  // the optic, since pulses would look like garbage code groups there.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      autoneg_en <= '0;
      link_pulse_en <= '0;
    end else begin
      for (int p = 0; p < PORTS; p++) begin
        autoneg_en[p] <= copper_only(fiber_mode[p], ctrl_r[p][PFMPC_BIT_ANEG]);
        link_pulse_en[p] <= copper_only(fiber_mode[p], ctrl_r[p][PFMPC_BIT_ANEG]);
      end
    end
  end

  // ----------------------------------------------------------------
  // Speed
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      slow_enable <= '0;
      port_fast <= '0;
    end else begin
      for (int p = 0; p < PORTS; p++) begin
        slow_enable[p] <= copper_only(fiber_mode[p], ~vend_r[p][PFMPC_BIT_TEN_OFF]);
        port_fast[p] <= fast_sel[p];
      end
    end
  end

  // ----------------------------------------------------------------
  // Bused-mode pin mapping
  // ----------------------------------------------------------------
  pfmpc_bus_route #(
    .PORTS(PORTS)
  ) u_route (
    .mode(bus_mode),
    .port_fast(fast_sel),
    .carrier_sense_slow(carrier_sense_slow),
    .carrier_sense_fast(carrier_sense_fast),
    .receive_enable_slow(receive_enable_slow),
    .receive_enable_fast(receive_enable_fast),
    .transmit_enable_slow(transmit_enable_slow),
    .transmit_enable_fast(transmit_enable_fast),
    .carrier_sense_out(cso_w),
    .rx_select(rxs_w),
    .tx_select(txs_w),
    .to_bus_a(bua_w),
    .to_bus_b(bub_w),
    .security(sec_w)
  );

  // Registered so every top output comes from a flop; one cycle of latency.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      carrier_sense_out <= '0;
      rx_select <= '0;
      tx_select <= '0;
      to_bus_a <= '0;
      to_bus_b <= '0;
      security <= '0;
    end else begin
      carrier_sense_out <= cso_w;
      rx_select <= rxs_w;
      tx_select <= txs_w;
      to_bus_a <= bua_w;
      to_bus_b <= bub_w;
      security <= sec_w;
    end
  end

endmodule
`default_nettype wire

// ==== verif/pfmpc_top_properties.sv ====
`timescale 1ns/10ps
`default_nettype none
module pfmpc_top_chk
  import pfmpc_pkg::*;
#(
  parameter int unsigned PORTS = PFMPC_PORTS
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [PFMPC_ADDR_W-1:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire pfmpc_bus_mode_t bus_mode,
  input wire logic [PORTS-1:0] transmit_enable_slow,
  input wire logic [PORTS-1:0] fiber_active,
  input wire logic [PORTS-1:0] far_fault_en,
  input wire logic [PORTS-1:0] line_code_bypass,
  input wire logic [PORTS-1:0] scramble_bypass,
  input wire logic [PORTS-1:0] autoneg_en,
  input wire logic [PORTS-1:0] link_pulse_en,
  input wire logic [PORTS-1:0] slow_enable,
  input wire logic [PORTS-1:0] port_fast,
  input wire logic [PORTS-1:0] rx_select,
  input wire logic [PORTS-1:0] to_bus_a,
  input wire logic [PORTS-1:0] to_bus_b,
  input wire logic [PORTS-1:0] security
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  code_bypass_a: assert property ((fiber_active & ~(line_code_bypass & scramble_bypass)) == '0)
    else $error("coder or scrambler left on in fiber mode");
  far_fault_a: assert property ((fiber_active & ~far_fault_en) == '0)
    else $error("far fault off in fiber mode");
  aneg_off_a: assert property ((fiber_active & (autoneg_en | link_pulse_en)) == '0)
    else $error("autoneg or pulses on in fiber mode");
  slow_off_a: assert property ((fiber_active & slow_enable) == '0)
    else $error("slow operation on in fiber mode");
  fiber_write_a: assert property (reg_wr && reg_addr[4:0] == PFMPC_REG_VEND |-> ##2
    fiber_active[$past(reg_addr[PFMPC_PORT_LSB +: 2], 2)] == $past(reg_wdata[0], 2))
    else $error("fiber bit write not followed");
  smart_sec_a: assert property (bus_mode == PFMPC_SMART |=>
    security == $past(transmit_enable_slow)) else $error("security pins wrong");
  bus_route_a: assert property (bus_mode != PFMPC_NORMAL && $stable(bus_mode) &&
    $stable(port_fast) ##1 $stable(port_fast) && $stable(bus_mode) |->
    to_bus_a == port_fast && to_bus_b == ~port_fast) else $error("bus route wrong");
  normal_idle_a: assert property (bus_mode == PFMPC_NORMAL |=>
    (rx_select | to_bus_a | to_bus_b) == '0) else $error("routes active in normal mode");
  cover property (reg_wr && reg_addr[4:0] == PFMPC_REG_VEND ##2 fiber_active != '0);
  cover property (bus_mode == PFMPC_SMART && security != '0);
  cover property (bus_mode == PFMPC_SEPARATE && rx_select != '0);
endmodule
bind pfmpc_top pfmpc_top_chk #(.PORTS(PORTS)) chk (.clk_sys, .rst, .reg_addr, .reg_wdata,
  .reg_wr, .bus_mode, .transmit_enable_slow, .fiber_active, .far_fault_en, .line_code_bypass,
  .scramble_bypass, .autoneg_en, .link_pulse_en, .slow_enable, .port_fast, .rx_select,
  .to_bus_a, .to_bus_b, .security);
`default_nettype wire

// ==== verif/pfmpc_far_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// Repeater and optic module stand-in.
// ----------------------------------------
module pfmpc_far_model (
  input wire logic clk_sys,
  input wire logic [1:0] pick,
  input wire logic fast,
  input wire logic go,
  input wire logic [3:0] light,
  output logic [3:0] carrier_sense_slow,
  output logic [3:0] carrier_sense_fast,
  output logic [3:0] receive_enable_slow,
  output logic [3:0] receive_enable_fast,
  output logic [3:0] transmit_enable_slow,
  output logic [3:0] transmit_enable_fast,
  output logic [3:0] optic_signal_detect
);
  logic [3:0] hot;
  assign hot = go ? 4'h1 << pick : 4'h0;
  always_ff @(posedge clk_sys) begin
    receive_enable_fast <= fast ? hot : 4'h0;
    transmit_enable_fast <= fast ? hot : 4'h0;
    carrier_sense_fast <= fast ? hot : 4'h0;
    receive_enable_slow <= fast ? 4'h0 : hot;
    transmit_enable_slow <= fast ? 4'h0 : hot;
    carrier_sense_slow <= fast ? 4'h0 : hot;
    optic_signal_detect <= light;
  end
endmodule
`default_nettype wire

// ==== verif/tb_port_fiber_mode_pin_config.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb_port_fiber_mode_pin_config;
  import pfmpc_pkg::*;
  logic clk_sys, rst, reg_wr, reg_rd, global_duplex_strap, go, fast;
  logic [PFMPC_ADDR_W-1:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata;
  logic [1:0] pick;
  logic [3:0] fiber_select_strap, link_fast, light, optic_signal_detect;
  logic [3:0] carrier_sense_slow, carrier_sense_fast, receive_enable_slow, receive_enable_fast;
  logic [3:0] transmit_enable_slow, transmit_enable_fast, fiber_active, full_duplex;
  logic [3:0] pins_to_fiber, signal_detect_on, signal_present, far_fault_en, line_code_bypass;
  logic [3:0] scramble_bypass, autoneg_en, link_pulse_en, slow_enable, port_fast;
  logic [3:0] carrier_sense_out, rx_select, tx_select, to_bus_a, to_bus_b, security;
  pfmpc_bus_mode_t bus_mode;
  int n_fail, checks;
  pfmpc_top dut (.clk_sys, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .fiber_select_strap, .global_duplex_strap, .optic_signal_detect, .link_fast, .bus_mode,
    .carrier_sense_slow, .carrier_sense_fast, .receive_enable_slow, .receive_enable_fast,
    .transmit_enable_slow, .transmit_enable_fast, .fiber_active, .full_duplex, .pins_to_fiber,
    .signal_detect_on, .signal_present, .far_fault_en, .line_code_bypass, .scramble_bypass,
    .autoneg_en, .link_pulse_en, .slow_enable, .port_fast, .carrier_sense_out, .rx_select,
    .tx_select, .to_bus_a, .to_bus_b, .security);
  pfmpc_far_model far (.clk_sys, .pick, .fast, .go, .light, .carrier_sense_slow,
    .carrier_sense_fast, .receive_enable_slow, .receive_enable_fast, .transmit_enable_slow,
    .transmit_enable_fast, .optic_signal_detect);
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic ck(input logic [15:0] g, input logic [15:0] e);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [1:0] p, input logic [4:0] r, input logic [15:0] d);
    @(posedge clk_sys);
    reg_addr <= {p, r};
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] p, input logic [4:0] r, input logic [15:0] e);
    @(posedge clk_sys);
    reg_addr <= {p, r};
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    ck(reg_rdata, e);
  endtask
  // Outputs trail the pins by up to two registers, so four edges leave margin.
  task automatic settle;
    repeat (4) @(posedge clk_sys);
    #1;
  endtask
  task automatic drv(input pfmpc_bus_mode_t m, input logic [1:0] k, input logic f);
    @(posedge clk_sys);
    bus_mode <= m;
    pick <= k;
    fast <= f;
    go <= 1'b1;
    settle;
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  initial begin
    #50000;
    n_fail++;
    end_of_test;
  end
  task automatic test_strap;
    ck(fiber_active, 4'h5);
    ck(full_duplex, 4'hF);
    rd(2'd0, PFMPC_REG_VEND, 16'h0001);
    rd(2'd1, PFMPC_REG_CTRL, 16'h0100);
    $display("strap test done");
  endtask
  task automatic test_fiber_select;
    wr(2'd0, PFMPC_REG_VEND, 16'h0000);
    wr(2'd1, PFMPC_REG_VEND, 16'h0001);
    settle;
    ck(fiber_active, 4'h6);
    ck(slow_enable, 4'h9);
    ck(far_fault_en, 4'h6);
    $display("fiber select test done");
  endtask
  task automatic test_forced;
    wr(2'd2, PFMPC_REG_CTRL, 16'h1000);
    wr(2'd3, PFMPC_REG_CTRL, 16'h1100);
    wr(2'd3, PFMPC_REG_VEND, 16'h000E);
    wr(2'd2, PFMPC_REG_VEND, 16'h0001);
    settle;
    ck(full_duplex, 4'hB);
    ck(autoneg_en, 4'h8);
    ck(link_pulse_en & 4'h6, 4'h0);
    ck(line_code_bypass, 4'hE);
    ck(scramble_bypass, 4'hE);
    $display("forced option test done");
  endtask
  task automatic test_detect;
    @(posedge clk_sys);
    light <= 4'h3;
    link_fast <= 4'h1;
    settle;
    ck(signal_present, 4'h2);
    ck(signal_detect_on & pins_to_fiber, 4'h6);
    ck(port_fast, 4'h7);
    wr(2'd1, PFMPC_REG_STAT, 16'hFFFF);
    rd(2'd1, PFMPC_REG_STAT, 16'h0007);
    rd(2'd0, 5'h03, PFMPC_UNMAPPED);
    $display("signal detect test done");
  endtask
  task automatic test_bused;
    drv(PFMPC_SEPARATE, 2'd3, 1'b1);
    ck(rx_select, 4'h0);
    ck({to_bus_a, to_bus_b}, 8'h78);
    drv(PFMPC_SEPARATE, 2'd3, 1'b0);
    ck({rx_select, tx_select}, 8'h88);
    drv(PFMPC_SMART, 2'd1, 1'b0);
    ck({security, carrier_sense_out}, 8'h20);
    drv(PFMPC_SMART, 2'd2, 1'b1);
    ck({security, carrier_sense_out}, 8'h04);
    drv(PFMPC_NORMAL, 2'd2, 1'b1);
    ck(rx_select | to_bus_a | to_bus_b, 4'h0);
    $display("bused mode test done");
  endtask
  initial begin
    rst = 1'b1;
    {reg_wr, reg_rd, go, fast, pick, reg_addr, reg_wdata} = '0;
    {link_fast, light} = '0;
    fiber_select_strap = 4'h5;
    global_duplex_strap = 1'b1;
    bus_mode = PFMPC_NORMAL;
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    settle;
    test_strap;
    test_fiber_select;
    test_forced;
    test_detect;
    test_bused;
    end_of_test;
  end
endmodule
`default_nettype wire
